// file: osp_pkg.sv
// package: codes, slot count and status carrier for the output select block
package osp_pkg;
    localparam int unsigned OSP_SLOTS      = 7;
    localparam int unsigned OSP_CODE_W     = 14;
    localparam int unsigned OSP_LINK_SLOT7 = 2;
    localparam logic [13:0] OSP_NEG_BASE   = 14'h0064;
    localparam logic [13:0] OSP_NEG_LIMIT  = 14'h00C8;
    localparam logic [13:0] OSP_NO_FUNC    = 14'h270F;
    localparam logic [6:0] C_RUN   = 7'h00;
    localparam logic [6:0] C_RDY   = 7'h0B;
    localparam logic [6:0] C_PID   = 7'h2F;
    localparam logic [6:0] C_RETRY = 7'h40;
    localparam logic [6:0] C_AUX   = 7'h44;
    localparam logic [6:0] C_STOPM = 7'h50;
    localparam logic [6:0] C_HLTH  = 7'h51;
    localparam logic [6:0] C_LIFE  = 7'h5A;
    localparam logic [6:0] C_IFAIL = 7'h5B;
    localparam logic [6:0] C_PULSE = 7'h5D;
    localparam logic [6:0] C_UPK   = 7'h5F;
    localparam logic [6:0] C_HOST  = 7'h60;
    localparam logic [6:0] C_MINOR = 7'h62;
    localparam logic [6:0] C_FAULT = 7'h63;
    localparam logic [13:0] OSP_RST_TERM  = 14'h0000;
    localparam logic [13:0] OSP_RST_SLOT7 = 14'h0063;

    typedef struct packed {
        logic brake_transistor;
        logic earth_fault;
        logic accel_overcurrent;
        logic phase_loss;
        logic param_storage;
        logic internal_board;
        logic cpu;
        logic inrush_circuit;
        logic other;
    } osp_fault_s;

    typedef struct packed {
        logic       can_start;
        logic       running;
        logic       freq_at_start;
        logic       dc_brake;
        logic       output_stop_input;
        logic       safety_stop;
        logic       aux_only;
        logic       safety_circuit_fail;
        logic       retry;
        logic       pid_running;
        logic       life_near_end;
        logic [31:0] upkeep_count;
        logic [31:0] upkeep_limit;
        logic       pulse_train;
        logic       warning;
    } osp_status_s;
endpackage : osp_pkg

// file: osp_output_select.sv
// output select block: status flags and per-output code routing with polarity
`timescale 1ns/100ps
//
// Contract
// [RULE1] any function routable to any output; the code refuses pulse codes 93 and 193 on slot 7
// [RULE2] codes 0-99 conduct, 100-199 invert
// [RULE3] one function may drive several outputs
// [RULE4] ready when startable or running, code 11
// [RULE5] running flag at start frequency, code 0
// [RULE6] running flag off when stopped or braking
// [RULE7] shutoff, reset, aux supply clear both
// [RULE8] terminal defaults to running flag
// [RULE9] fault flag defaults to slot, code 99
// [RULE10] fault flag held until fault reset
// [RULE11] internal failure for listed faults, code 91
// [RULE12] accel overcurrent earth fault still counts
// [RULE13] stop monitor while safety stop, code 80
// [RULE14] healthy when no safety circuit fault; the code also drops it on a cpu fault
// [RULE15] aux supply flag, code 68
// [RULE16] retry flag during retry, code 64
// [RULE17] loop control flag, code 47
// [RULE18] lifetime alarm on end of life, code 90
// [RULE19] upkeep flag when count reaches limit
// [RULE20] pulse code 93 refused on slot 7
// [RULE21] host output follows written value, code 96
// [RULE22] minor alarm on warnings, code 98
// [RULE23] unknown code holds output off
// [RULE24] code change acts next cycle only
module osp_output_select
    import osp_pkg::*;
#(
    parameter int unsigned SLOTS = OSP_SLOTS
) (
    input  wire logic                   ref_clk_i,
    input  wire logic                   reset_i,
    input  wire osp_status_s            status_i,
    input  wire osp_fault_s             fault_i,
    input  wire logic                   fault_reset_i,
    input  wire logic [SLOTS-1:0]       host_value_i,
    input  wire logic [SLOTS-1:0]       sel_we_i,
    input  wire logic [OSP_CODE_W-1:0]  sel_code_i,
    output logic [SLOTS-1:0]            out_on_o,
    output logic [SLOTS-1:0]            sel_reject_o,
    output logic                        drive_ready_flag_o,
    output logic                        motor_output_active_o,
    output logic                        fault_flag_o
);
    // slot 0 is the physical terminal, the rest are link bits
    typedef struct packed {
        logic [SLOTS-1:0][OSP_CODE_W-1:0] sel;
        logic [SLOTS-1:0]                 out_on;
        logic [SLOTS-1:0]                 reject;
        logic                             fault;
        logic                             ready;
        logic                             run;
    } osp_state_s;

    osp_state_s state_reg;
    osp_state_s state_next;

    logic any_fault;
    logic shutoff;
    logic ifail;
    logic [SLOTS-1:0] func_on;

    assign any_fault = |fault_i;
    assign shutoff   = state_reg.fault | any_fault | status_i.output_stop_input | status_i.safety_stop;
    // accel overcurrent is reported this way on its own, with or without an earth fault
    assign ifail = fault_i.brake_transistor | fault_i.earth_fault | fault_i.accel_overcurrent
                 | fault_i.phase_loss | fault_i.param_storage | fault_i.internal_board
                 | fault_i.cpu | fault_i.inrush_circuit; // see [RULE11] see [RULE12]

    function automatic logic pick(input logic [OSP_CODE_W-1:0] code, input int unsigned slot,
                                  input osp_state_s s, input logic hv, input logic inf);
        logic [6:0] f;
        logic v;
        logic known;
        f = 7'h00;
        v = 1'b0;
        known = 1'b1;
        if (code < OSP_NEG_BASE)
            f = code[6:0];
        else
            f = 7'((code - OSP_NEG_BASE));
        unique case (f)
            C_RUN:   v = s.run;
            C_RDY:   v = s.ready;
            C_PID:   v = status_i.pid_running;                                 // see [RULE17]
            C_RETRY: v = status_i.retry;                                       // see [RULE16]
            C_AUX:   v = status_i.aux_only;                                    // see [RULE15]
            C_STOPM: v = status_i.safety_stop;                                 // see [RULE13]
            C_HLTH:  v = ~(status_i.safety_circuit_fail | fault_i.cpu);        // see [RULE14]
            C_LIFE:  v = status_i.life_near_end;                               // see [RULE18]
            C_IFAIL: v = inf;
            C_PULSE: v = (slot == OSP_LINK_SLOT7) ? 1'b0 : status_i.pulse_train; // see [RULE20]
            C_UPK:   v = status_i.upkeep_count >= status_i.upkeep_limit;       // see [RULE19]
            C_HOST:  v = hv;                                                   // see [RULE21]
            C_MINOR: v = status_i.warning;                                     // see [RULE22]
            C_FAULT: v = s.fault;
            default: begin
                v = 1'b0;
                known = 1'b0;
            end
        endcase
        // outside 0..199, or an undefined function, the output stays off in either polarity
        if (code >= OSP_NEG_LIMIT || !known)
            pick = 1'b0;                                                       // see [RULE23]
        else if (code >= OSP_NEG_BASE)
            pick = ~v;                                                         // see [RULE2]
        else
            pick = v;
    endfunction : pick

    genvar g;
    generate
        for (g = 0; g < SLOTS; g++) begin : g_slot
            // each slot evaluates independently, so functions may repeat
            assign func_on[g] = pick(state_reg.sel[g], g, state_reg, host_value_i[g], ifail); // see [RULE1] see [RULE3]
        end
    endgenerate

    always_comb begin
        state_next = state_reg;
        // fault set wins over reset in the same cycle
        if (any_fault)
            state_next.fault = 1'b1;                                           // see [RULE10]
        else if (fault_reset_i)
            state_next.fault = 1'b0;
        state_next.ready = (status_i.can_start | status_i.running)
                         & ~shutoff & ~status_i.aux_only;                      // see [RULE4] see [RULE7]
        state_next.run = status_i.running & status_i.freq_at_start & ~status_i.dc_brake
                       & ~shutoff & ~status_i.aux_only;                        // see [RULE5] see [RULE6] see [RULE7]
        for (int i = 0; i < SLOTS; i++) begin
            state_next.reject[i] = 1'b0;
            if (sel_we_i[i]) begin
                if (i == OSP_LINK_SLOT7 && (sel_code_i == 14'(C_PULSE)
                    || sel_code_i == OSP_NEG_BASE + 14'(C_PULSE)))
                    state_next.reject[i] = 1'b1;                               // see [RULE20]
                else
                    state_next.sel[i] = sel_code_i;                            // see [RULE24]
            end
        end
        state_next.out_on = func_on;
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            state_reg <= '0;
            for (int i = 0; i < SLOTS; i++)
                state_reg.sel[i] <= OSP_NO_FUNC;
            state_reg.sel[0] <= OSP_RST_TERM;                                  // see [RULE8]
            state_reg.sel[OSP_LINK_SLOT7] <= OSP_RST_SLOT7;                    // see [RULE9]
        end else begin
            state_reg <= state_next;
        end
    end

    assign out_on_o              = state_reg.out_on;
    assign sel_reject_o          = state_reg.reject;
    assign drive_ready_flag_o    = state_reg.ready;
    assign motor_output_active_o = state_reg.run;
    assign fault_flag_o          = state_reg.fault;

    property p_fault_hold;
        @(posedge ref_clk_i) disable iff (reset_i)
        fault_flag_o && !fault_reset_i |=> fault_flag_o;
    endproperty
    a_fault_hold: assert property (p_fault_hold) else $error("fault flag dropped without reset"); // see [RULE10]

    property p_fault_set;
        @(posedge ref_clk_i) disable iff (reset_i)
        any_fault |=> fault_flag_o;
    endproperty
    a_fault_set: assert property (p_fault_set) else $error("fault flag not set"); // see [RULE10]

    property p_shutoff_clear;
        @(posedge ref_clk_i) disable iff (reset_i)
        (status_i.output_stop_input || status_i.safety_stop || status_i.aux_only)
            |=> !drive_ready_flag_o && !motor_output_active_o;
    endproperty
    a_shutoff_clear: assert property (p_shutoff_clear) else $error("flags on during shutoff"); // see [RULE7]

    property p_brake_off;
        @(posedge ref_clk_i) disable iff (reset_i)
        status_i.dc_brake || !status_i.running |=> !motor_output_active_o;
    endproperty
    a_brake_off: assert property (p_brake_off) else $error("running flag on while stopped"); // see [RULE6]

    property p_ready_on;
        @(posedge ref_clk_i) disable iff (reset_i)
        status_i.can_start && !shutoff && !status_i.aux_only |=> drive_ready_flag_o;
    endproperty
    a_ready_on: assert property (p_ready_on) else $error("ready flag missing"); // see [RULE4]

    property p_bad_code_off;
        @(posedge ref_clk_i) disable iff (reset_i)
        state_reg.sel[0] >= OSP_NEG_LIMIT |=> !out_on_o[0];
    endproperty
    a_bad_code_off: assert property (p_bad_code_off) else $error("undefined code conducts"); // see [RULE23]

    property p_slot7_reject;
        @(posedge ref_clk_i) disable iff (reset_i)
        sel_we_i[OSP_LINK_SLOT7] && sel_code_i == 14'(C_PULSE)
            |=> sel_reject_o[OSP_LINK_SLOT7] && state_reg.sel[OSP_LINK_SLOT7] == $past(state_reg.sel[OSP_LINK_SLOT7]);
    endproperty
    a_slot7_reject: assert property (p_slot7_reject) else $error("pulse code accepted on slot 7"); // see [RULE20]

    property p_invert;
        @(posedge ref_clk_i) disable iff (reset_i)
        state_reg.sel[0] == OSP_NEG_BASE + 14'(C_RUN) && $stable(state_reg.sel[0])
            |=> out_on_o[0] == !$past(motor_output_active_o);
    endproperty
    a_invert: assert property (p_invert) else $error("inverted polarity wrong"); // see [RULE2]

    property p_sel_latency;
        @(posedge ref_clk_i) disable iff (reset_i)
        sel_we_i[1] && !sel_we_i[0] |=> state_reg.sel[1] == $past(sel_code_i) && $stable(state_reg.sel[0]);
    endproperty
    a_sel_latency: assert property (p_sel_latency) else $error("selection not applied next cycle"); // see [RULE24]

    property p_rdy_route;
        @(posedge ref_clk_i) disable iff (reset_i)
        state_reg.sel[1] == 14'(C_RDY) |=> out_on_o[1] == $past(drive_ready_flag_o);
    endproperty
    a_rdy_route: assert property (p_rdy_route) else $error("ready flag not routed"); // see [RULE4]

    property p_run_route;
        @(posedge ref_clk_i) disable iff (reset_i)
        state_reg.sel[1] == 14'(C_RUN) |=> out_on_o[1] == $past(motor_output_active_o);
    endproperty
    a_run_route: assert property (p_run_route) else $error("running flag not routed"); // see [RULE5]

    property p_pid_route;
        @(posedge ref_clk_i) disable iff (reset_i)
        state_reg.sel[1] == 14'(C_PID) |=> out_on_o[1] == $past(status_i.pid_running);
    endproperty
    a_pid_route: assert property (p_pid_route) else $error("loop control flag not routed"); // see [RULE17]

    property p_retry_route;
        @(posedge ref_clk_i) disable iff (reset_i)
        state_reg.sel[1] == 14'(C_RETRY) |=> out_on_o[1] == $past(status_i.retry);
    endproperty
    a_retry_route: assert property (p_retry_route) else $error("retry flag not routed"); // see [RULE16]

    property p_aux_route;
        @(posedge ref_clk_i) disable iff (reset_i)
        state_reg.sel[1] == 14'(C_AUX) |=> out_on_o[1] == $past(status_i.aux_only);
    endproperty
    a_aux_route: assert property (p_aux_route) else $error("aux supply flag not routed"); // see [RULE15]

    property p_stopm_route;
        @(posedge ref_clk_i) disable iff (reset_i)
        state_reg.sel[1] == 14'(C_STOPM) |=> out_on_o[1] == $past(status_i.safety_stop);
    endproperty
    a_stopm_route: assert property (p_stopm_route) else $error("stop monitor not routed"); // see [RULE13]

    property p_hlth_route;
        @(posedge ref_clk_i) disable iff (reset_i)
        state_reg.sel[1] == 14'(C_HLTH) |=> out_on_o[1] == !$past(status_i.safety_circuit_fail || fault_i.cpu);
    endproperty
    a_hlth_route: assert property (p_hlth_route) else $error("healthy flag not routed"); // see [RULE14]

    property p_life_route;
        @(posedge ref_clk_i) disable iff (reset_i)
        state_reg.sel[1] == 14'(C_LIFE) |=> out_on_o[1] == $past(status_i.life_near_end);
    endproperty
    a_life_route: assert property (p_life_route) else $error("lifetime alarm not routed"); // see [RULE18]

    property p_ifail_route;
        @(posedge ref_clk_i) disable iff (reset_i)
        state_reg.sel[1] == 14'(C_IFAIL) && (fault_i.phase_loss || fault_i.accel_overcurrent)
            |=> out_on_o[1];
    endproperty
    a_ifail_route: assert property (p_ifail_route) else $error("internal failure not shown"); // see [RULE11] see [RULE12]

    property p_upk_route;
        @(posedge ref_clk_i) disable iff (reset_i)
        state_reg.sel[1] == 14'(C_UPK) |=> out_on_o[1] == $past(status_i.upkeep_count >= status_i.upkeep_limit);
    endproperty
    a_upk_route: assert property (p_upk_route) else $error("upkeep flag not routed"); // see [RULE19]

    property p_host_route;
        @(posedge ref_clk_i) disable iff (reset_i)
        state_reg.sel[1] == 14'(C_HOST) |=> out_on_o[1] == $past(host_value_i[1]);
    endproperty
    a_host_route: assert property (p_host_route) else $error("host value not routed"); // see [RULE21]

    property p_minor_route;
        @(posedge ref_clk_i) disable iff (reset_i)
        state_reg.sel[1] == 14'(C_MINOR) |=> out_on_o[1] == $past(status_i.warning);
    endproperty
    a_minor_route: assert property (p_minor_route) else $error("minor alarm not routed"); // see [RULE22]

    property p_fault_route;
        @(posedge ref_clk_i) disable iff (reset_i)
        state_reg.sel[1] == 14'(C_FAULT) |=> out_on_o[1] == $past(fault_flag_o);
    endproperty
    a_fault_route: assert property (p_fault_route) else $error("fault flag not routed"); // see [RULE9]

    property p_neg_route;
        @(posedge ref_clk_i) disable iff (reset_i)
        state_reg.sel[3] == OSP_NEG_BASE + 14'(C_PID) |=> out_on_o[3] == !$past(status_i.pid_running);
    endproperty
    a_neg_route: assert property (p_neg_route) else $error("inverted slot wrong"); // see [RULE2] see [RULE3]

    property p_neg_undef;
        @(posedge ref_clk_i) disable iff (reset_i)
        state_reg.sel[4] == OSP_NEG_BASE + 14'h0002 |=> !out_on_o[4];
    endproperty
    a_neg_undef: assert property (p_neg_undef) else $error("undefined inverted code conducts"); // see [RULE23]

    property p_reset_dflt;
        @(posedge ref_clk_i) disable iff (reset_i)
        $fell(reset_i) |-> state_reg.sel[0] == OSP_RST_TERM && state_reg.sel[OSP_LINK_SLOT7] == OSP_RST_SLOT7;
    endproperty
    a_reset_dflt: assert property (p_reset_dflt) else $error("reset selections wrong"); // see [RULE8] see [RULE9]

    property p_reset_flags;
        @(posedge ref_clk_i) disable iff (reset_i)
        $fell(reset_i) |-> !drive_ready_flag_o && !motor_output_active_o;
    endproperty
    a_reset_flags: assert property (p_reset_flags) else $error("flags on after reset"); // see [RULE7]

    property p_run_ready;
        @(posedge ref_clk_i) disable iff (reset_i)
        status_i.running && !shutoff && !status_i.aux_only |=> drive_ready_flag_o;
    endproperty
    a_run_ready: assert property (p_run_ready) else $error("ready dropped while running"); // see [RULE4]

    property p_run_on;
        @(posedge ref_clk_i) disable iff (reset_i)
        status_i.running && status_i.freq_at_start && !status_i.dc_brake && !shutoff && !status_i.aux_only
            |=> motor_output_active_o;
    endproperty
    a_run_on: assert property (p_run_on) else $error("running flag missing"); // see [RULE5]

    property p_fault_shut;
        @(posedge ref_clk_i) disable iff (reset_i)
        fault_flag_o |=> !drive_ready_flag_o && !motor_output_active_o;
    endproperty
    a_fault_shut: assert property (p_fault_shut) else $error("flags on while faulted"); // see [RULE7]

    property p_other_slot;
        @(posedge ref_clk_i) disable iff (reset_i)
        sel_we_i[3] && !sel_we_i[1] |=> $stable(state_reg.sel[1]);
    endproperty
    a_other_slot: assert property (p_other_slot) else $error("write disturbed another slot"); // see [RULE24]

    property p_slot7_keep;
        @(posedge ref_clk_i) disable iff (reset_i)
        sel_reject_o[OSP_LINK_SLOT7] |-> state_reg.sel[OSP_LINK_SLOT7] != 14'(C_PULSE);
    endproperty
    a_slot7_keep: assert property (p_slot7_keep) else $error("pulse code held on slot 7"); // see [RULE20]

    c_fault_out: cover property (@(posedge ref_clk_i) disable iff (reset_i) fault_flag_o ##1 !fault_flag_o);
    c_run_out:   cover property (@(posedge ref_clk_i) disable iff (reset_i) out_on_o[0] && motor_output_active_o);
    c_reject:    cover property (@(posedge ref_clk_i) disable iff (reset_i) |sel_reject_o);
    c_multi:     cover property (@(posedge ref_clk_i) disable iff (reset_i)
                                 state_reg.sel[1] == state_reg.sel[3] && out_on_o[1] && out_on_o[3]);
endmodule : osp_output_select

// file: osp_plc_model.sv
// supervising controller model: reads the status outputs and writes the remote values
`timescale 1ns/100ps
module osp_plc_model
    import osp_pkg::*;
(
    input  wire logic [OSP_SLOTS-1:0] host_word_i,
    input  wire logic                 ref_clk_i,
    input  wire logic                 reset_i,
    input  wire logic [OSP_SLOTS-1:0] out_on_i,
    input  wire logic [OSP_SLOTS-1:0] reject_i,
    input  wire logic [2:0]           flags_i,
    output logic      [OSP_SLOTS-1:0] host_value_o,
    output logic      [16:0]          seen_o
);
    // the remote setting changes only when the host writes it, one clock after the request
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            host_value_o <= 7'h00;
        end else begin
            host_value_o <= host_word_i;
        end
    end
    assign seen_o = {reject_i, out_on_i, flags_i};
endmodule : osp_plc_model

// file: osp_output_select_tb_top.sv
// testbench: output select block driven with status stimulus, results checked from a note queue
`timescale 1ns/100ps
module osp_output_select_tb_top;
    import osp_pkg::*;
    typedef struct packed {
        logic [31:0] at;
        logic [16:0] m;
        logic [16:0] e;
    } osp_note_s;
    logic        ref_clk_i   = 1'b0;
    logic        reset_i     = 1'b1;
    osp_status_s st          = '0;
    osp_fault_s  fault_v     = '0;
    logic        frst        = 1'b0;
    logic [6:0]  hword       = 7'h00;
    logic [6:0]  we          = 7'h00;
    logic [13:0] code        = 14'h270F;
    logic [6:0]  hval;
    logic [6:0]  out_on;
    logic [6:0]  rej;
    logic [2:0]  flags;
    logic [16:0] seen;
    logic        want;
    int          cyc         = 0;
    int          fail_count  = 0;
    int          comparisons = 0;
    osp_note_s   q[$];
    logic [6:0]  fn[14] = '{C_RDY, C_RUN, C_PID, C_RETRY, C_AUX, C_STOPM, C_HLTH, C_LIFE, C_IFAIL, C_IFAIL,
                           C_UPK, C_HOST, C_MINOR, C_FAULT};

    osp_output_select u_osp_output_select (
        .ref_clk_i             (ref_clk_i),
        .reset_i               (reset_i),
        .status_i              (st),
        .fault_i               (fault_v),
        .fault_reset_i         (frst),
        .host_value_i          (hval),
        .sel_we_i              (we),
        .sel_code_i            (code),
        .out_on_o              (out_on),
        .sel_reject_o          (rej),
        .drive_ready_flag_o    (flags[2]),
        .motor_output_active_o (flags[1]),
        .fault_flag_o          (flags[0])
    );
    osp_plc_model u_osp_plc_model (
        .host_word_i  (hword),
        .ref_clk_i    (ref_clk_i),
        .reset_i      (reset_i),
        .out_on_i     (out_on),
        .reject_i     (rej),
        .flags_i      (flags),
        .host_value_o (hval),
        .seen_o       (seen)
    );

    always #2 ref_clk_i = ~ref_clk_i;
    always @(posedge ref_clk_i) cyc <= cyc + 1;

    task automatic step(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask : step
    task automatic note(input int d, input logic [16:0] m, input logic [16:0] e);
        q.push_back('{32'(cyc + d), m, e});
    endtask : note
    task automatic sel(input logic [6:0] w, input logic [13:0] c);
        we   = w;
        code = c;
        step(1);
        we   = 7'h00;
    endtask : sel
    task automatic check(input logic [16:0] s, input logic [16:0] e);
        comparisons++;
        if (s !== e) begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, s, e);
        end
    endtask : check
    // each stim call is one function's stimulus: index into fn, active or idle
    task automatic stim(input int i, input bit on);
        logic [31:0] lim;
        lim     = $urandom_range(1000, 1);
        st      = '0;
        fault_v = '0;
        hword   = 7'h00;
        frst    = !on;
        case (i)
            0: st.can_start = on;
            1: begin
                st.running       = on;
                st.freq_at_start = on;
            end
            2: st.pid_running = on;
            3: st.retry = on;
            4: st.aux_only = on;
            5: st.safety_stop = on;
            6: st.safety_circuit_fail = on;
            7: st.life_near_end = on;
            8: fault_v.phase_loss = on;
            9: fault_v.accel_overcurrent = on;
            10: begin
                st.upkeep_limit = lim;
                st.upkeep_count = on ? lim : lim - 32'h1;
            end
            11: hword = on ? 7'h7F : 7'h00;
            12: st.warning = on;
            default: fault_v.other = on;
        endcase
    endtask : stim
    task automatic end_of_test;
        // a note never reached means the monitor lost step with the drivers
        if (q.size() != 0)
            fail_count++;
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_of_test

    // the monitor looks after the drivers' +1 ns updates so no race with the edge remains
    always @(posedge ref_clk_i) begin
        #2;
        while (q.size() > 0 && q[0].at == cyc) begin
            check(seen & q[0].m, q[0].e & q[0].m); // tags stand where each note is queued
            void'(q.pop_front());
        end
    end

    initial begin
        #4000;
        fail_count++;
        end_of_test();
    end

    initial begin
        void'($urandom(32'h8F86));
        step(2);
        reset_i = 1'b0;
        note(1, 17'h1FFFF, 17'h00000);
        step(1);
        st.can_start     = 1'b1;
        st.running       = 1'b1;
        st.freq_at_start = 1'b1;
        note(3, 17'h0000F, 17'h0000E);
        step(4);
        st.dc_brake = 1'b1;
        note(3, 17'h0000F, 17'h00004);
        step(4);
        st.dc_brake          = 1'b0;
        st.output_stop_input = 1'b1;
        note(3, 17'h0000F, 17'h00000);
        step(4);
        st.output_stop_input = 1'b0;
        sel(7'h06, {7'h00, C_PULSE});
        note(0, 17'h1FC00, 17'h01000);
        note(1, 17'h1FC00, 17'h00000);
        fault_v.other  = 1'b1;
        st.pulse_train = 1'b1;
        step(1);
        fault_v.other = 1'b0;
        note(3, 17'h0003F, 17'h00031);
        step(4);
        frst = 1'b1;
        note(3, 17'h0002F, 17'h0000E);
        step(4);
        for (int i = 0; i < 14; i++) begin
            sel(7'h02, {7'h00, fn[i]});
            stim(i, 1'b1);
            sel(7'h08, {7'h00, fn[i]} + OSP_NEG_BASE);
            want = (fn[i] != C_HLTH);
            note(4, 17'h00050, {10'h000, !want, 1'b0, want, 4'h0});
            step(5);
            stim(i, 1'b0);
            note(5, 17'h00050, {10'h000, want, 1'b0, !want, 4'h0});
            step(6); // also through the table
        end
        sel(7'h02, OSP_NO_FUNC);
        sel(7'h08, 14'h00FA);
        sel(7'h10, 14'h0066);
        st    = '1;
        hword = 7'h7F;
        note(4, 17'h000D0, 17'h00000);
        step(6);
        end_of_test();
    end
endmodule : osp_output_select_tb_top
